// *** fcs_cfg.svh ***
// fcs_cfg.svh: offsets, field positions, reset values and codes of the
// flash command/status block. Assumes a 32-bit byte address bus.
`ifndef FCS_CFG_SVH
`define FCS_CFG_SVH

// -----------------------------------------------------------------
// register addresses
// -----------------------------------------------------------------
`define FCS_ADDR_MCR    32'h00D0_0000
`define FCS_ADDR_TSTAT  32'h00D0_001C
`define FCS_ADDR_USTAT  32'h00D0_0018
`define FCS_ADDR_CMD    32'h00D0_0020
`define FCS_ADDR_TCTL   32'h00D0_0024
`define FCS_ADDR_TADR   32'h00D0_0026
`define FCS_ADDR_TDATA  32'h00D0_0028

// -----------------------------------------------------------------
// user status fields
// -----------------------------------------------------------------
`define FCS_ST_BUFFER_EMPTY_FLAG    3'h7
`define FCS_ST_CMD_COMPLETE_FLAG     3'h6
`define FCS_ST_PROTECT_VIOLATION_FLAG    3'h5
`define FCS_ST_ACCESS_ERROR_FLAG   3'h4
`define FCS_ST_BLANK    3'h2
`define FCS_ST_W_MASK   8'hB4

// -----------------------------------------------------------------
// module configuration fields
// -----------------------------------------------------------------
`define FCS_MCR_BUFFER_EMPTY_IRQ_EN   3'h7
`define FCS_MCR_CMD_COMPLETE_IRQ_EN    3'h6
`define FCS_MCR_BKSEL   3'h0

// -----------------------------------------------------------------
// command codes and reset values
// -----------------------------------------------------------------
`define FCS_CMD_VERIFY  7'h05
`define FCS_CMD_PROG    7'h20
`define FCS_CMD_PAGE_ERASE_CMD   7'h40
`define FCS_CMD_MASS_ERASE_CMD  7'h41
`define FCS_CMD_RST     7'h00
`define FCS_MAX_BANKS   4

`endif

// *** fcs_pkg.sv ***
// fcs_pkg.sv: types of the flash command/status block.
// Assumes fcs_cfg.svh is on the include path.
`include "fcs_cfg.svh"

package fcs_pkg;

    typedef enum logic [2:0] {
        FCS_PH_IDLE   = 3'b001,
        FCS_PH_LOADED = 3'b010,
        FCS_PH_RUN    = 3'b100
    } fcs_phase_t;

    typedef enum logic [4:0] {
        FCS_K_NONE   = 5'b00001,
        FCS_K_VERIFY = 5'b00010,
        FCS_K_PROG   = 5'b00100,
        FCS_K_PAGE_ERASE_CMD  = 5'b01000,
        FCS_K_MASS_ERASE_CMD = 5'b10000
    } fcs_kind_t;

    typedef struct packed {
        fcs_phase_t  phase;
        logic        buffer_empty_flag;
        logic        cmd_complete_flag;
        logic        protect_violation_flag;
        logic        access_error_flag;
        logic        blank;
        logic [6:0]  cmd;
    } fcs_bank_t;

endpackage

// *** fcs_dec_if.sv ***
// fcs_dec_if.sv: command code to decoder and decoded kind back.
// Assumes fcs_pkg is compiled first.
`timescale 1ns/1ps

interface fcs_dec_if;
    import fcs_pkg::*;
    logic [6:0] code;
    logic       legal;
    fcs_kind_t  kind;
    modport user (output code, input legal, input kind);
    modport dec  (input code, output legal, output kind);
endinterface

// *** fcs_cmd_dec.sv ***
// fcs_cmd_dec.sv: decodes a 7-bit command field into its kind.
// Assumes the code is stable within the cycle; purely combinational.
`timescale 1ns/1ps
`include "fcs_cfg.svh"

module fcs_cmd_dec
    import fcs_pkg::*;
(
    fcs_dec_if.dec  dif
);

    always_comb begin
        dif.legal = 1'b1;
        case (dif.code)
            `FCS_CMD_VERIFY: dif.kind = FCS_K_VERIFY;
            `FCS_CMD_PROG:   dif.kind = FCS_K_PROG;
            `FCS_CMD_PAGE_ERASE_CMD:  dif.kind = FCS_K_PAGE_ERASE_CMD;
            `FCS_CMD_MASS_ERASE_CMD: dif.kind = FCS_K_MASS_ERASE_CMD;
            default: begin
                dif.kind  = FCS_K_NONE;
                dif.legal = 1'b0;
            end
        endcase
    end

endmodule

// *** fcs_flash_cmd_status.sv ***
// fcs_flash_cmd_status.sv: banked user status and command registers of
// the flash program/erase controller, with launch, abort and errors.
// Assumes a synchronous one-cycle register port and an outside engine
// that runs launched commands and reports completion per bank.
`timescale 1ns/1ps
`include "fcs_cfg.svh"

module fcs_flash_cmd_status
    import fcs_pkg::*;
#(
    parameter int NUM_BANKS = 2
)(
    input  wire logic        i_core_clk,
    input  wire logic        i_rst,
    input  wire logic [31:0] i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata,
    output logic             o_xfer_err,
    input  wire logic        i_test_mode,
    input  wire logic        i_done,
    input  wire logic [1:0]  i_done_bank,
    input  wire logic        i_blank_ok,
    input  wire logic        i_prot_viol,
    input  wire logic        i_acc_err,
    input  wire logic [1:0]  i_evt_bank,
    output logic             o_launch,
    output logic      [1:0]  o_launch_bank,
    output logic      [6:0]  o_launch_cmd,
    output logic             o_irq
);

    // -----------------------------------------------------------------
    // parameter check
    // -----------------------------------------------------------------
    if (NUM_BANKS < 1 || NUM_BANKS > `FCS_MAX_BANKS) begin : g_bad
        $error("NUM_BANKS must be 1 to 4");
    end

    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    typedef struct packed {
        fcs_bank_t [NUM_BANKS-1:0] bank;
        logic                      buffer_empty_irq_en;
        logic                      cmd_complete_irq_en;
        logic      [1:0]           bksel;
        logic      [31:0]          rdata;
        logic                      xfer_err;
        logic                      launch;
        logic      [1:0]           launch_bank;
        logic      [6:0]           launch_cmd;
    } fcs_state_t;

    fcs_state_t state_reg;
    fcs_state_t state_next;

    // -----------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------
    // set wins over clear so a same-cycle event is never lost
    function automatic logic fcs_sc(input logic cur,
                                    input logic set,
                                    input logic clr);
        return set | (cur & ~clr);
    endfunction

    function automatic logic [7:0] fcs_stat_byte(input fcs_bank_t b);
        logic [7:0] v;
        v = 8'h00;
        v[`FCS_ST_BUFFER_EMPTY_FLAG]  = b.buffer_empty_flag;
        v[`FCS_ST_CMD_COMPLETE_FLAG]   = b.cmd_complete_flag;
        v[`FCS_ST_PROTECT_VIOLATION_FLAG]  = b.protect_violation_flag;
        v[`FCS_ST_ACCESS_ERROR_FLAG] = b.access_error_flag;
        v[`FCS_ST_BLANK]  = b.blank;
        return v;
    endfunction

    function automatic logic fcs_bank_hit(input logic [1:0] sel,
                                          input int         idx);
        return (32'(sel) == idx);
    endfunction

    // -----------------------------------------------------------------
    // command decoder
    // -----------------------------------------------------------------
    fcs_dec_if dif ();

    assign dif.code = i_wdata[6:0];

    fcs_cmd_dec u_dec (
        .dif (dif)
    );

    // -----------------------------------------------------------------
    // address decode
    // -----------------------------------------------------------------
    logic hit_mcr;
    logic hit_ustat;
    logic hit_cmd;
    logic hit_test;
    logic sel_ok;
    logic err_any;
    logic [NUM_BANKS-1:0] err_vec;

    assign hit_mcr   = (i_addr == `FCS_ADDR_MCR);
    assign hit_ustat = (i_addr == `FCS_ADDR_USTAT);
    assign hit_cmd   = (i_addr == `FCS_ADDR_CMD);
    assign hit_test  = (i_addr == `FCS_ADDR_TSTAT) ||
                       (i_addr == `FCS_ADDR_TCTL)  ||
                       (i_addr == `FCS_ADDR_TADR)  ||
                       (i_addr == `FCS_ADDR_TDATA);
    assign sel_ok    = (32'(state_reg.bksel) < NUM_BANKS);

    always_comb begin
        for (int b = 0; b < NUM_BANKS; b++) begin
            err_vec[b] = state_reg.bank[b].protect_violation_flag | state_reg.bank[b].access_error_flag;
        end
    end

    assign err_any = |err_vec;

    // -----------------------------------------------------------------
    // next state
    // -----------------------------------------------------------------
    always_comb begin
        logic       sel;
        logic       st_wr;
        logic       cmd_wr;
        logic       done_b;
        logic       evt_b;
        logic       set_acc;
        logic       set_pv;
        logic       set_blank;
        logic [7:0] rd_byte;
        fcs_bank_t  cur;
        fcs_bank_t  nb;

        sel       = 1'b0;
        st_wr     = 1'b0;
        cmd_wr    = 1'b0;
        done_b    = 1'b0;
        evt_b     = 1'b0;
        set_acc   = 1'b0;
        set_pv    = 1'b0;
        set_blank = 1'b0;
        rd_byte   = 8'h00;
        cur       = '0;
        nb        = '0;

        state_next             = state_reg;
        state_next.rdata       = 32'h0000_0000;
        state_next.xfer_err    = 1'b0;
        state_next.launch      = 1'b0;

        // test registers only answer in test mode
        if ((i_wr || i_rd) && hit_test && !i_test_mode) begin
            state_next.xfer_err = 1'b1;
        end

        if (i_wr && hit_mcr) begin
            state_next.buffer_empty_irq_en = i_wdata[`FCS_MCR_BUFFER_EMPTY_IRQ_EN];
            state_next.cmd_complete_irq_en  = i_wdata[`FCS_MCR_CMD_COMPLETE_IRQ_EN];
            state_next.bksel = i_wdata[`FCS_MCR_BKSEL +: 2];
        end

        for (int b = 0; b < NUM_BANKS; b++) begin
            cur    = state_reg.bank[b];
            nb     = cur;
            sel    = fcs_bank_hit(state_reg.bksel, b);
            st_wr  = i_wr && hit_ustat && sel;
            cmd_wr = i_wr && hit_cmd && sel;
            done_b = i_done && fcs_bank_hit(i_done_bank, b);
            evt_b  = fcs_bank_hit(i_evt_bank, b);

            set_pv  = i_prot_viol && evt_b;
            set_acc = i_acc_err && evt_b;
            set_blank = 1'b0;

            if (i_rd && hit_ustat && sel) begin
                rd_byte = fcs_stat_byte(cur);
            end
            if (i_rd && hit_cmd && sel) begin
                rd_byte = {1'b0, cur.cmd};
            end

            case (cur.phase)
                FCS_PH_IDLE: begin
                    // blocked while the buffer holds a command
                    if (cmd_wr && cur.buffer_empty_flag) begin
                        nb.cmd = i_wdata[6:0];
                        if (dif.legal) begin
                            nb.phase = FCS_PH_LOADED;
                        end else begin
                            set_acc = 1'b1;
                        end
                    end
                    if (st_wr && i_wdata[`FCS_ST_BUFFER_EMPTY_FLAG]) begin
                        // launch with nothing loaded is a bad sequence
                        set_acc = 1'b1;
                    end
                end
                FCS_PH_LOADED: begin
                    if (cmd_wr) begin
                        nb.cmd = i_wdata[6:0];
                        if (!dif.legal) begin
                            set_acc  = 1'b1;
                            nb.phase = FCS_PH_IDLE;
                        end
                    end else if (st_wr && !i_wdata[`FCS_ST_BUFFER_EMPTY_FLAG]) begin
                        set_acc  = 1'b1;
                        nb.phase = FCS_PH_IDLE;
                    end else if (st_wr && i_wdata[`FCS_ST_BUFFER_EMPTY_FLAG] && !err_any) begin
                        nb.phase  = FCS_PH_RUN;
                        nb.buffer_empty_flag  = 1'b0;
                        nb.cmd_complete_flag   = 1'b0;
                        state_next.launch      = 1'b1;
                        state_next.launch_bank = 2'(b);
                        state_next.launch_cmd  = cur.cmd;
                    end
                    if (set_pv) begin
                        nb.phase = FCS_PH_IDLE;
                    end
                end
                FCS_PH_RUN: begin
                    if (st_wr && i_wdata[`FCS_ST_BUFFER_EMPTY_FLAG]) begin
                        set_acc = 1'b1;
                    end
                    if (done_b || set_pv || set_acc) begin
                        // completion or self-abort frees the buffer
                        nb.phase = FCS_PH_IDLE;
                        nb.buffer_empty_flag = 1'b1;
                        nb.cmd_complete_flag  = 1'b1;
                        set_blank = done_b && i_blank_ok &&
                                    (cur.cmd == `FCS_CMD_VERIFY);
                    end
                end
                default: begin
                    nb.phase = FCS_PH_IDLE;
                    nb.buffer_empty_flag = 1'b1;
                    nb.cmd_complete_flag  = 1'b1;
                end
            endcase

            // write-1-to-clear flags; bit 6 never written
            nb.protect_violation_flag  = fcs_sc(cur.protect_violation_flag, set_pv,
                               st_wr && i_wdata[`FCS_ST_PROTECT_VIOLATION_FLAG]);
            nb.access_error_flag = fcs_sc(cur.access_error_flag, set_acc,
                               st_wr && i_wdata[`FCS_ST_ACCESS_ERROR_FLAG]);
            nb.blank  = fcs_sc(cur.blank, set_blank,
                               st_wr && i_wdata[`FCS_ST_BLANK]);

            state_next.bank[b] = nb;
        end

        if (i_rd && hit_mcr) begin
            rd_byte = 8'h00;
            rd_byte[`FCS_MCR_BUFFER_EMPTY_IRQ_EN]      = state_reg.buffer_empty_irq_en;
            rd_byte[`FCS_MCR_CMD_COMPLETE_IRQ_EN]       = state_reg.cmd_complete_irq_en;
            rd_byte[`FCS_MCR_BKSEL +: 2] = state_reg.bksel;
        end

        // out-of-range bank select and test registers read zero
        if (i_rd && (hit_mcr || sel_ok)) begin
            state_next.rdata = {24'h00_0000, rd_byte};
        end
    end

    // -----------------------------------------------------------------
    // registers
    // -----------------------------------------------------------------
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            for (int b = 0; b < NUM_BANKS; b++) begin
                state_reg.bank[b].phase  <= FCS_PH_IDLE;
                state_reg.bank[b].buffer_empty_flag  <= 1'b1;
                state_reg.bank[b].cmd_complete_flag   <= 1'b1;
                state_reg.bank[b].protect_violation_flag  <= 1'b0;
                state_reg.bank[b].access_error_flag <= 1'b0;
                state_reg.bank[b].blank  <= 1'b0;
                state_reg.bank[b].cmd    <= `FCS_CMD_RST;
            end
            state_reg.buffer_empty_irq_en       <= 1'b0;
            state_reg.cmd_complete_irq_en        <= 1'b0;
            state_reg.bksel       <= 2'h0;
            state_reg.rdata       <= 32'h0000_0000;
            state_reg.xfer_err    <= 1'b0;
            state_reg.launch      <= 1'b0;
            state_reg.launch_bank <= 2'h0;
            state_reg.launch_cmd  <= 7'h00;
        end else begin
            state_reg <= state_next;
        end
    end

    // -----------------------------------------------------------------
    // outputs
    // -----------------------------------------------------------------
    logic [NUM_BANKS-1:0] irq_vec;

    always_comb begin
        for (int b = 0; b < NUM_BANKS; b++) begin
            irq_vec[b] = (state_reg.bank[b].buffer_empty_flag & state_reg.buffer_empty_irq_en) |
                         (state_reg.bank[b].cmd_complete_flag & state_reg.cmd_complete_irq_en);
        end
    end

    // any bank may raise the request, not only the selected one
    assign o_irq         = |irq_vec;
    assign o_rdata       = state_reg.rdata;
    assign o_xfer_err    = state_reg.xfer_err;
    assign o_launch      = state_reg.launch;
    assign o_launch_bank = state_reg.launch_bank;
    assign o_launch_cmd  = state_reg.launch_cmd;

endmodule

// *** fcs_flash_cmd_status_properties.sv ***
// fcs_flash_cmd_status_properties.sv: port checker of the flash
// command/status block. Assumes only the top module's ports are visible.
`timescale 1ns/1ps
`include "fcs_cfg.svh"

module fcs_props #(
    parameter int NUM_BANKS = 2
)(
    input wire logic        i_core_clk,
    input wire logic        i_rst,
    input wire logic [31:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic        o_xfer_err,
    input wire logic        i_test_mode,
    input wire logic        i_done,
    input wire logic [1:0]  i_done_bank,
    input wire logic        i_blank_ok,
    input wire logic        i_prot_viol,
    input wire logic        i_acc_err,
    input wire logic [1:0]  i_evt_bank,
    input wire logic        o_launch,
    input wire logic [1:0]  o_launch_bank,
    input wire logic [6:0]  o_launch_cmd,
    input wire logic        o_irq
);
    // -------------------------------------------------------------
    // helper state
    // -------------------------------------------------------------
    logic [1:0] en_reg;
    logic [1:0] sel_reg;
    logic [3:0] busy_reg;
    logic       bad;
    logic       st_rd;

    assign bad   = (i_rd | i_wr) && !i_test_mode && (i_addr inside {`FCS_ADDR_TSTAT,
                   `FCS_ADDR_TCTL, `FCS_ADDR_TADR, `FCS_ADDR_TDATA});
    assign st_rd = i_rd && i_addr == `FCS_ADDR_USTAT;

    // busy is dropped on any abort path too, so it never claims a run that ended
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            en_reg   <= 2'h0;
            sel_reg  <= 2'h0;
            busy_reg <= 4'h0;
        end else begin
            if (i_wr && i_addr == `FCS_ADDR_MCR) begin
                en_reg  <= i_wdata[7:6];
                sel_reg <= i_wdata[1:0];
            end
            busy_reg <= (busy_reg | ({3'h0, o_launch} << o_launch_bank))
                & ~({3'h0, i_done} << i_done_bank)
                & ~({3'h0, i_prot_viol | i_acc_err} << i_evt_bank)
                & ~({3'h0, i_wr && i_addr == `FCS_ADDR_USTAT && i_wdata[7]} << sel_reg);
        end
    end

    // -------------------------------------------------------------
    // properties
    // -------------------------------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    xfer_err_a: assert property (
        bad |=> o_xfer_err) else $error("no transfer error on test register");
    err_cause_a: assert property (
        o_xfer_err |-> $past(bad)) else $error("transfer error without cause");
    stat_zero_a: assert property (
        st_rd |=> o_rdata[3] == 1'b0 && o_rdata[1:0] == 2'h0)
        else $error("unused status bits not zero");
    cmd_top_a: assert property (
        i_rd && i_addr == `FCS_ADDR_CMD |=> o_rdata[31:7] == 25'h0)
        else $error("command top bit not zero");
    launch_cause_a: assert property (
        o_launch |-> $past(i_wr) && $past(i_wdata[7]) && $past(i_addr) == `FCS_ADDR_USTAT)
        else $error("launch without status write of one");
    launch_code_a: assert property (
        o_launch |-> o_launch_cmd inside {`FCS_CMD_VERIFY, `FCS_CMD_PROG,
        `FCS_CMD_PAGE_ERASE_CMD, `FCS_CMD_MASS_ERASE_CMD}) else $error("launch of illegal code");
    irq_off_a: assert property (
        en_reg == 2'h0 |-> !o_irq) else $error("interrupt with enables clear");
    busy_flags_a: assert property (
        st_rd && busy_reg[sel_reg] |=> o_rdata[7:6] == 2'h0)
        else $error("flags set while command runs");
endmodule

bind fcs_flash_cmd_status fcs_props #(.NUM_BANKS(NUM_BANKS)) u_props (.*);

// *** fcs_engine_model.sv ***
// fcs_engine_model.sv: behavioural program/erase engine on the far side.
// Assumes one launch pulse per command and a bench-set run length.
`timescale 1ns/1ps

module fcs_engine_model
    import fcs_pkg::*;
(
    input  wire logic       i_core_clk,
    input  wire logic       i_rst,
    input  wire logic       i_launch,
    input  wire logic [1:0] i_launch_bank,
    input  wire logic [7:0] i_run_len,
    input  wire logic       i_blank,
    output logic            o_done,
    output logic      [1:0] o_done_bank,
    output logic            o_blank_ok
);
    logic [7:0] cnt_reg;
    logic [1:0] bank_reg;
    logic       done_reg;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_reg  <= 8'h00;
            bank_reg <= 2'h0;
            done_reg <= 1'b0;
        end else begin
            done_reg <= cnt_reg == 8'h01;
            if (i_launch) begin
                cnt_reg  <= i_run_len;
                bank_reg <= i_launch_bank;
            end else if (cnt_reg != 8'h00) begin
                cnt_reg <= cnt_reg - 8'h01;
            end
        end
    end

    // outside the pulse the lines carry junk, never the last value
    assign o_done      = done_reg;
    assign o_done_bank = done_reg ? bank_reg : ~bank_reg;
    assign o_blank_ok  = done_reg ? i_blank : ~i_blank;
endmodule

// *** fcs_flash_cmd_status_tb.sv ***
// fcs_flash_cmd_status_tb.sv: self-checking bench of the flash
// command/status block. Assumes the engine model and the bound checker.
`timescale 1ns/1ps
`include "fcs_cfg.svh"

module fcs_flash_cmd_status_tb;
    import fcs_pkg::*;
    logic        i_core_clk;
    logic        i_rst;
    logic [31:0] i_addr;
    logic [31:0] i_wdata;
    logic        i_wr;
    logic        i_rd;
    logic [31:0] o_rdata;
    logic        o_xfer_err;
    logic        i_test_mode;
    logic        i_done;
    logic [1:0]  i_done_bank;
    logic        i_blank_ok;
    logic        i_prot_viol;
    logic        i_acc_err;
    logic [1:0]  i_evt_bank;
    logic        o_launch;
    logic [1:0]  o_launch_bank;
    logic [6:0]  o_launch_cmd;
    logic        o_irq;
    logic        blank;
    logic [7:0]  run_len;
    int          n_fail;
    int          tests_run;

    fcs_flash_cmd_status #(.NUM_BANKS(2)) uut (.*);
    fcs_engine_model u_eng (.i_core_clk, .i_rst, .i_launch(o_launch),
        .i_launch_bank(o_launch_bank), .i_run_len(run_len), .i_blank(blank),
        .o_done(i_done), .o_done_bank(i_done_bank), .o_blank_ok(i_blank_ok));

    always #12.5 i_core_clk = ~i_core_clk;

    // -------------------------------------------------------------
    // bus and check tasks
    // -------------------------------------------------------------
    task automatic final_report();
        if (n_fail == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (s !== e) begin
            $display("unexpected %s expected %h seen %h", n, e, s);
            n_fail++;
        end
    endtask

    task automatic acc(input logic w, input logic [31:0] a, input logic [7:0] d,
                       input logic e_err);
        @(posedge i_core_clk);
        i_addr  <= a;
        i_wdata <= {24'h0, d};
        i_wr    <= w;
        i_rd    <= ~w;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
        i_rd <= 1'b0;
        #1;
        chk("xfer_err", {31'h0, e_err}, {31'h0, o_xfer_err});
    endtask

    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        acc(1'b1, a, d, 1'b0);
    endtask

    task automatic rd(input logic [31:0] a, input logic [7:0] e);
        acc(1'b0, a, 8'h00, 1'b0);
        chk("rdata", {24'h0, e}, o_rdata);
    endtask

    task automatic wait_done();
        for (int i = 0; i < 300 && i_done !== 1'b1; i++) begin
            @(posedge i_core_clk);
            #1;
        end
        if (i_done !== 1'b1) begin
            chk("done_wait", 32'h1, 32'h0);
            final_report();
        end else begin
            @(posedge i_core_clk);
            #1;
        end
    endtask

    // -------------------------------------------------------------
    // scenarios
    // -------------------------------------------------------------
    task automatic t_regs();
        logic [31:0] ta [4];
        ta = '{`FCS_ADDR_TSTAT, `FCS_ADDR_TCTL, `FCS_ADDR_TADR, `FCS_ADDR_TDATA};
        chk("irq", 32'h0, {31'h0, o_irq});
        rd(`FCS_ADDR_USTAT, 8'hC0);
        rd(`FCS_ADDR_CMD, 8'h00);
        foreach (ta[i]) begin
            acc(1'b0, ta[i], 8'h00, 1'b1);
            acc(1'b1, ta[i], 8'hFF, 1'b1);
            @(posedge i_core_clk) i_test_mode <= 1'b1;
            rd(ta[i], 8'h00);
            @(posedge i_core_clk) i_test_mode <= 1'b0;
        end
        rd(32'h00D0_0030, 8'h00);
        wr(`FCS_ADDR_USTAT, 8'h0B);
        rd(`FCS_ADDR_USTAT, 8'hC0);
        wr(`FCS_ADDR_MCR, 8'h40);
        chk("irq", 32'h1, {31'h0, o_irq});
        wr(`FCS_ADDR_MCR, 8'h80);
        chk("irq", 32'h1, {31'h0, o_irq});
    endtask

    task automatic t_cmds();
        logic [6:0] code [5];
        logic       bl   [5];
        code = '{`FCS_CMD_VERIFY, `FCS_CMD_PROG, `FCS_CMD_PAGE_ERASE_CMD, `FCS_CMD_MASS_ERASE_CMD,
                 `FCS_CMD_VERIFY};
        bl   = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
        foreach (code[i]) begin
            blank   = bl[i];
            run_len = i[0] ? 8'h0A : 8'h40;
            wr(`FCS_ADDR_CMD, {1'b1, code[i]});
            rd(`FCS_ADDR_CMD, {1'b0, code[i]});
            wr(`FCS_ADDR_USTAT, 8'h80);
            chk("launch", {23'h0, 2'h0, 1'b1, code[i]},
                {23'h0, o_launch_bank, o_launch, o_launch_cmd});
            wr(`FCS_ADDR_USTAT, 8'h40);
            rd(`FCS_ADDR_USTAT, 8'h00);
            wr(`FCS_ADDR_CMD, 8'h7F);
            rd(`FCS_ADDR_CMD, {1'b0, code[i]});
            wait_done();
            rd(`FCS_ADDR_USTAT, {5'h18, bl[i] & (code[i] == `FCS_CMD_VERIFY), 2'h0});
            wr(`FCS_ADDR_USTAT, 8'h04);
            rd(`FCS_ADDR_USTAT, 8'hC0);
        end
    endtask

    task automatic t_errs();
        logic [7:0] m;
        wr(`FCS_ADDR_CMD, 8'h7F);
        rd(`FCS_ADDR_USTAT, 8'hD0);
        wr(`FCS_ADDR_USTAT, 8'h10);
        rd(`FCS_ADDR_USTAT, 8'hC0);
        wr(`FCS_ADDR_CMD, 8'h20);
        wr(`FCS_ADDR_USTAT, 8'h00);
        rd(`FCS_ADDR_USTAT, 8'hD0);
        wr(`FCS_ADDR_USTAT, 8'h10);
        // error flag raised in the other bank must still block this bank
        for (int k = 0; k < 2; k++) begin
            m = k[0] ? 8'h10 : 8'h20;
            wr(`FCS_ADDR_CMD, 8'h40);
            @(posedge i_core_clk);
            i_prot_viol <= ~k[0];
            i_acc_err   <= k[0];
            i_evt_bank  <= 2'h1;
            @(posedge i_core_clk);
            i_prot_viol <= 1'b0;
            i_acc_err   <= 1'b0;
            wr(`FCS_ADDR_USTAT, 8'h80);
            chk("launch", 32'h0, {31'h0, o_launch});
            wr(`FCS_ADDR_MCR, 8'h01);
            rd(`FCS_ADDR_USTAT, 8'hC0 | m);
            wr(`FCS_ADDR_USTAT, m);
            rd(`FCS_ADDR_USTAT, 8'hC0);
            wr(`FCS_ADDR_MCR, 8'h00);
            chk("irq", 32'h0, {31'h0, o_irq});
            wr(`FCS_ADDR_USTAT, 8'h80);
            chk("launch", 32'h1, {31'h0, o_launch});
            wait_done();
        end
    endtask

    initial begin
        i_core_clk  = 1'b0;
        i_rst       = 1'b1;
        i_addr      = 32'h0;
        i_wdata     = 32'h0;
        i_wr        = 1'b0;
        i_rd        = 1'b0;
        i_test_mode = 1'b0;
        i_prot_viol = 1'b0;
        i_acc_err   = 1'b0;
        i_evt_bank  = 2'h0;
        blank       = 1'b0;
        run_len     = 8'h0A;
        n_fail      = 0;
        tests_run   = 0;
        repeat (6) @(posedge i_core_clk);
        i_rst <= 1'b0;
        t_regs();
        t_cmds();
        t_errs();
        final_report();
    end
endmodule
